/* File: hw/angle_spi_pkg.sv */
package angle_spi_pkg;
    // register indices
    localparam logic [6:0] idx_angle_upper = 7'h03;
    localparam logic [6:0] idx_angle_middle = 7'h04;
    localparam logic [6:0] idx_angle_lower = 7'h05;
    // frame layout
    localparam int frame_cmd_bits = 8;
    localparam int data_bits = 8;
    localparam logic [3:0] bit_count_last = 4'h7;
    // field positions
    localparam int pos_field_flag = 1;
    localparam int pos_upper_parity = 0;
    localparam int pos_speed_flag = 3;
    localparam int pos_lower_parity = 2;
    // values after reset
    localparam logic [17:0] angle_reset = 18'h00000;
    localparam logic [7:0] byte_reset = 8'h00;
    localparam logic [6:0] index_reset = 7'h00;
    localparam logic [1:0] sync_reset = 2'h3;
    // pin levels
    localparam logic serial_idle = 1'b1;
    // timing
    localparam int clk_period_ns = 100;
    localparam int select_setup_ns = 100;
    localparam int select_setup_cycles =
        (select_setup_ns + clk_period_ns - 1) / clk_period_ns;
endpackage

/* File: hw/sync2.sv */
`timescale 1ns/1ps
module sync2
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // async level in, synced level out
    input wire logic async_in,
    output logic sync_out
);
    import angle_spi_pkg::*;

    logic [1:0] stage_r;

    // =====================================================
    // two-flop synchroniser
    always_ff @(posedge clk)
    begin
        if (!rstn)
            stage_r <= sync_reset;
        else
            stage_r <= {stage_r[0], async_in};
    end

    assign sync_out = stage_r[1];
endmodule

/* File: hw/angle_sensor_spi_readout.sv */
`timescale 1ns/1ps
// Summary of operation
// - fault pin low when healthy, high on weak field or overspeed
// - wire-count setting: 0 four-wire, 1 three-wire shared data line
// - spi mode 3: clock idles high, capture on rising edge
// - frame starts on select falling, ends on select rising
// - device samples incoming bits on serial clock rising edges
// - drivers change after falling edge, receiver captures on rising
// - first frame bit: low means write, high means read
// - bits one to seven carry seven-bit index, msb first
// - read data byte shifted out in bits eight to fifteen, msb first
// - four-wire: receive on mosi, transmit on miso
// - three-wire: one shared line carries command, index and data
// - angle split over indices 0x03, 0x04[7:2], 0x05[7:4]
// - weak-field flag in bit one of index 0x04
// - over-rotation flag in bit three of index 0x05
// - bit zero of 0x04 is even parity over 0x03 and 0x04[7:1]
// - bit two of 0x05 is even parity over 0x05[7:3]
// - burst read returns several angle bytes in one transaction
module angle_sensor_spi_readout
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // sensor core
    input wire logic [17:0] angle_value,
    input wire logic weak_field,
    input wire logic over_speed,
    // one-time wire-count setting
    input wire logic three_wire_mode,
    // spi pins
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // shared serial line in three-wire form
    input wire logic shared_serial_line_in,
    output logic shared_serial_line_out,
    output logic shared_serial_line_oe,
    // fault indicator
    output logic fault_out,
    // write strobe toward configuration store
    output logic write_strobe,
    output logic [6:0] write_index,
    output logic [7:0] write_payload
);
    import angle_spi_pkg::*;

    typedef enum logic [1:0] {st_idle, st_command, st_data} phase_e;

    logic cs_n_s;
    logic sck_s;
    logic mosi_s;
    logic line_s;
    logic sck_d_r;
    logic cs_d_r;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic rx_bit;
    phase_e phase_r;
    logic [3:0] count_r;
    logic [7:0] shift_r;
    logic read_r;
    logic [6:0] index_r;
    logic [7:0] tx_r;
    logic [17:0] angle_r;
    logic weak_r;
    logic speed_r;
    logic [7:0] reg_upper;
    logic [7:0] reg_middle;
    logic [7:0] reg_lower;
    logic [7:0] read_byte;
    logic [7:0] next_byte;

    // =====================================================
    // pin synchronisers
    sync2 u_sync_cs
    (
        .clk(clk),
        .rstn(rstn),
        .async_in(chip_select_n),
        .sync_out(cs_n_s)
    );
    sync2 u_sync_sck
    (
        .clk(clk),
        .rstn(rstn),
        .async_in(sck),
        .sync_out(sck_s)
    );
    sync2 u_sync_mosi
    (
        .clk(clk),
        .rstn(rstn),
        .async_in(mosi),
        .sync_out(mosi_s)
    );
    sync2 u_sync_line
    (
        .clk(clk),
        .rstn(rstn),
        .async_in(shared_serial_line_in),
        .sync_out(line_s)
    );

    // =====================================================
    // edge detection
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sck_d_r <= serial_idle;
            cs_d_r <= serial_idle;
        end
        else
        begin
            sck_d_r <= sck_s;
            cs_d_r <= cs_n_s;
        end
    end

    assign sck_rise = sck_s && !sck_d_r;
    assign sck_fall = !sck_s && sck_d_r;
    assign cs_fall = !cs_n_s && cs_d_r;
    assign cs_rise = cs_n_s && !cs_d_r;
    assign rx_bit = three_wire_mode ? line_s : mosi_s;

    // =====================================================
    // register contents
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            angle_r <= angle_reset;
            weak_r <= 1'b0;
            speed_r <= 1'b0;
        end
        else if (cs_fall)
        begin
            // snapshot so a burst sees one coherent angle
            angle_r <= angle_value;
            weak_r <= weak_field;
            speed_r <= over_speed;
        end
    end

    always_comb
    begin
        reg_upper = angle_r[17:10];
        reg_middle = {angle_r[9:4], weak_r, 1'b0};
        reg_middle[pos_upper_parity] =
            ^{reg_upper, reg_middle[7:1]};
        reg_lower = {angle_r[3:0], speed_r, 3'h0};
        reg_lower[pos_lower_parity] = ^reg_lower[7:3];
    end

    function automatic logic [7:0] pick(input logic [6:0] idx,
        input logic [7:0] u, input logic [7:0] m, input logic [7:0] l);
        begin
            unique case (idx)
                idx_angle_upper: pick = u;
                idx_angle_middle: pick = m;
                idx_angle_lower: pick = l;
                default: pick = byte_reset;
            endcase
        end
    endfunction

    assign read_byte = pick({shift_r[5:0], rx_bit},
        reg_upper, reg_middle, reg_lower);
    assign next_byte = pick(7'(index_r + 7'h01),
        reg_upper, reg_middle, reg_lower);

    // =====================================================
    // frame sequencer
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            phase_r <= st_idle;
            count_r <= 4'h0;
            shift_r <= byte_reset;
            read_r <= 1'b0;
            index_r <= index_reset;
        end
        else if (cs_rise || cs_n_s)
        begin
            phase_r <= st_idle;
            count_r <= 4'h0;
        end
        else if (cs_fall)
        begin
            phase_r <= st_command;
            count_r <= 4'h0;
        end
        else if (sck_rise && phase_r == st_command)
        begin
            shift_r <= {shift_r[6:0], rx_bit};
            count_r <= 4'(count_r + 4'h1);
            if (count_r == 4'h0)
                read_r <= rx_bit;
            if (count_r == bit_count_last)
            begin
                index_r <= {shift_r[5:0], rx_bit};
                phase_r <= st_data;
                count_r <= 4'h0;
            end
        end
        else if (sck_rise && phase_r == st_data)
        begin
            shift_r <= {shift_r[6:0], rx_bit};
            count_r <= 4'(count_r + 4'h1);
            if (count_r == bit_count_last)
            begin
                count_r <= 4'h0;
                if (read_r)
                    index_r <= 7'(index_r + 7'h01);
            end
        end
    end

    // =====================================================
    // write strobe
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            write_strobe <= 1'b0;
            write_index <= index_reset;
            write_payload <= byte_reset;
        end
        else
        begin
            write_strobe <= 1'b0;
            if (sck_rise && phase_r == st_data && !read_r
                && count_r == bit_count_last && !cs_n_s)
            begin
                write_strobe <= 1'b1;
                write_index <= index_r;
                write_payload <= {shift_r[6:0], rx_bit};
            end
        end
    end

    // =====================================================
    // transmit path
    always_ff @(posedge clk)
    begin
        if (!rstn)
            tx_r <= byte_reset;
        else if (sck_rise && phase_r == st_command
            && count_r == bit_count_last)
            tx_r <= read_byte;
        else if (sck_rise && phase_r == st_data
            && count_r == bit_count_last)
            tx_r <= next_byte;
        else if (sck_fall && phase_r == st_data && count_r != 4'h0)
            tx_r <= {tx_r[6:0], 1'b0};
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            miso <= 1'b0;
            shared_serial_line_out <= 1'b0;
            shared_serial_line_oe <= 1'b0;
        end
        else
        begin
            miso <= tx_r[7];
            shared_serial_line_out <= tx_r[7];
            shared_serial_line_oe <= three_wire_mode && !cs_n_s
                && read_r && phase_r == st_data;
        end
    end

    // =====================================================
    // fault indicator
    always_ff @(posedge clk)
    begin
        if (!rstn)
            fault_out <= 1'b0;
        else
            fault_out <= weak_field || over_speed;
    end
endmodule

/* File: verification/angle_spi_props.sv */
`timescale 1ns/1ps
// ====
// pin checker
module angle_spi_props
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // watched pins
    input wire logic weak_field,
    input wire logic over_speed,
    input wire logic three_wire_mode,
    input wire logic chip_select_n,
    input wire logic shared_serial_line_oe,
    input wire logic fault_out,
    input wire logic write_strobe,
    input wire logic [6:0] write_index,
    input wire logic [7:0] write_payload
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence deselected;
        chip_select_n [*8];
    endsequence
    sequence deselect_edge;
        $rose(chip_select_n);
    endsequence
    a_fault_raise: assert property
        ((weak_field || over_speed) |=> fault_out)
        else $error("fault pin not raised");
    a_fault_clear: assert property
        ((!weak_field && !over_speed) |=> !fault_out)
        else $error("fault pin high while healthy");
    a_oe_four_off: assert property
        (!three_wire_mode |-> !shared_serial_line_oe)
        else $error("shared line driven in four-wire form");
    a_oe_idle_off: assert property
        (deselected |-> !shared_serial_line_oe)
        else $error("shared line driven while deselected");
    a_oe_release: assert property
        (deselect_edge |-> ##[1:8] !shared_serial_line_oe)
        else $error("shared line not released after deselect");
    a_strobe_single: assert property
        (write_strobe |=> !write_strobe)
        else $error("write strobe longer than one cycle");
    a_write_with_strobe: assert property
        (($changed(write_index) || $changed(write_payload)) |-> write_strobe)
        else $error("write fields changed without strobe");
    a_strobe_idle: assert property
        (deselected |-> !write_strobe)
        else $error("write strobe while deselected");
endmodule

/* File: verification/spi_host_model.sv */
`timescale 1ns/1ps
// ====
// spi master model, mode 3, 800 ns clock
module spi_host_model
(
    // clock and mode
    input wire logic clk,
    input wire logic three_wire_mode,
    // spi pins
    output logic chip_select_n,
    output logic sck,
    output logic mosi,
    input wire logic miso,
    output logic line_out,
    output logic line_oe,
    input wire logic line_in
);
    initial
    begin
        chip_select_n = 1'b1;
        sck = 1'b1;
        mosi = 1'b0;
        line_out = 1'b0;
        line_oe = 1'b0;
    end
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wd,
        input int nd, output logic [23:0] rd);
        logic b;
        rd = 24'h000000;
        chip_select_n <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 8 + nd; i++)
        begin
            sck <= 1'b0;
            @(posedge clk);
            b = (i < 8) ? cmd[7 - i] : wd[31 - i];
            mosi <= b;
            line_out <= b;
            line_oe <= three_wire_mode && (i < 8 || !cmd[7]);
            repeat (3) @(posedge clk);
            sck <= 1'b1;
            @(posedge clk);
            rd = {rd[22:0], three_wire_mode ? line_in : miso};
            if (i == 7 && cmd[7])
                line_oe <= 1'b0;
            repeat (3) @(posedge clk);
        end
        chip_select_n <= 1'b1;
        mosi <= ~mosi;
        line_oe <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule

/* File: verification/angle_sensor_spi_readout_bench.sv */
`timescale 1ns/1ps
// ====
// bench
module angle_sensor_spi_readout_bench import angle_spi_pkg::*;;
    logic clk, rstn, weak_field, over_speed, three_wire_mode;
    logic chip_select_n, sck, mosi, miso, line_out, line_oe, line;
    logic host_out, host_oe, fault_out, write_strobe, wf, os;
    logic [17:0] angle_value, ang;
    logic [6:0] write_index;
    logic [7:0] write_payload;
    logic [23:0] rd, expv;
    logic [7:0] expb;
    int fail_count = 0;
    int num_checks = 0;
    int strobes = 0;
    int s0;
    assign line = line_oe ? line_out : host_oe ? host_out : ~line_out;
    angle_sensor_spi_readout dut
    (
        .clk(clk), .rstn(rstn), .angle_value(angle_value),
        .weak_field(weak_field), .over_speed(over_speed),
        .three_wire_mode(three_wire_mode), .chip_select_n(chip_select_n),
        .sck(sck), .mosi(mosi), .miso(miso),
        .shared_serial_line_in(line), .shared_serial_line_out(line_out),
        .shared_serial_line_oe(line_oe), .fault_out(fault_out),
        .write_strobe(write_strobe), .write_index(write_index),
        .write_payload(write_payload)
    );
    spi_host_model host
    (
        .clk(clk), .three_wire_mode(three_wire_mode),
        .chip_select_n(chip_select_n), .sck(sck), .mosi(mosi),
        .miso(miso), .line_out(host_out), .line_oe(host_oe), .line_in(line)
    );
    function automatic logic [23:0] regs(input logic [17:0] a,
        input logic w, input logic o);
        logic [7:0] u, m, l;
        u = a[17:10];
        m = {a[9:4], w, 1'b0};
        m[0] = ^u ^ ^m[7:1];
        l = {a[3:0], o, 3'h0};
        l[2] = ^l[7:3];
        regs = {u, m, l};
    endfunction
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
        if (write_strobe === 1'b1)
            strobes <= strobes + 1;
    initial
    begin
        repeat (100000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        rstn = 1'b0;
        angle_value = 18'h00000;
        weak_field = 1'b0;
        over_speed = 1'b0;
        three_wire_mode = 1'b0;
        repeat (10) @(posedge clk);
        check(24'({miso, line_oe, fault_out, write_strobe}), 24'h0);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        for (int m = 0; m < 2; m++)
        begin
            ang = m[0] ? 18'h1A5C6 : 18'h2D5A3;
            wf = !m[0];
            os = m[0];
            expv = regs(ang, wf, os);
            three_wire_mode <= m[0];
            angle_value <= ang;
            weak_field <= wf;
            over_speed <= os;
            repeat (2) @(posedge clk);
            check(24'(fault_out), 24'h1);
            for (int k = 0; k < 4; k++)
            begin
                host.frame({1'b1, idx_angle_upper + 7'(k)}, 24'h0, 8, rd);
                expb = (k < 3) ? expv[23 - 8 * k -: 8] : 8'h00;
                check(24'(rd[7:0]), 24'(expb));
            end
            host.frame({1'b1, idx_angle_upper}, 24'h0, 24, rd);
            check(rd, expv);
            s0 = strobes;
            host.frame({1'b0, 7'h11}, {8'hA5, 16'h0}, 8, rd);
            check(24'(strobes - s0), 24'h1);
            expv = 24'({7'h11, 8'hA5});
            check(24'({write_index, write_payload}), expv);
        end
        weak_field <= 1'b0;
        over_speed <= 1'b0;
        repeat (2) @(posedge clk);
        check(24'(fault_out), 24'h0);
        report_and_stop();
    end
endmodule
bind angle_sensor_spi_readout angle_spi_props props
(
    .clk(clk), .rstn(rstn), .weak_field(weak_field),
    .over_speed(over_speed), .three_wire_mode(three_wire_mode),
    .chip_select_n(chip_select_n),
    .shared_serial_line_oe(shared_serial_line_oe), .fault_out(fault_out),
    .write_strobe(write_strobe), .write_index(write_index),
    .write_payload(write_payload)
);
